// *** dv/crrsf_card_model.sv ***
`timescale 1ns/100ps

module crrsf_card_model
(
    input wire logic clk,
    input wire logic rst_n,
    input wire logic [1:0] cardResetN,
    input wire logic cardSupplyGood,
    output int releases,
    output logic badRelease
);
    logic [1:0] prevReset_reg;

    // A card starts its answer on each rising reset; a rise without supply leaves it undefined.
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            prevReset_reg <= 2'h0;
            releases <= 0;
            badRelease <= 1'b0;
        end
        else
        begin
            prevReset_reg <= cardResetN;
            if ((cardResetN & ~prevReset_reg) != 2'h0)
            begin
                releases <= releases + 1;
                badRelease <= badRelease | !cardSupplyGood;
            end
        end
    end
endmodule : crrsf_card_model

// *** dv/testbench.sv ***
`timescale 1ns/100ps

module testbench import crrsf_pkg::*;;
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    crrsf_apb_req_t req = '0;
    crrsf_apb_rsp_t rsp;
    logic etuTick = 1'b0;
    logic supplyGood = 1'b0;
    logic [0:0] sel = 1'b0;
    logic [7:0] vdd = 8'hff;
    logic [1:0] resetN;
    logic deact;
    logic irq;
    logic [31:0] rd;
    logic er;
    logic badRelease;
    int releases;
    int fails = 0;
    int checks_done = 0;
    int cycles = 0;
    int seed = 32'h5491_3e29;
    logic [7:0] shadow [int];

    crrsf_top dut (.clk(clk), .rst_n(rst_n), .apbReq(req), .apbRsp(rsp), .etuTick(etuTick),
        .cardSupplyGood(supplyGood), .cardSelect(sel), .vddAboveThr(vdd), .cardResetN(resetN),
        .cardDeactivate(deact), .irq(irq));
    crrsf_card_model card (.clk(clk), .rst_n(rst_n), .cardResetN(resetN),
        .cardSupplyGood(supplyGood), .releases(releases), .badRelease(badRelease));

    // Free-running system clock.
    initial
    begin
        forever #5 clk = ~clk;
    end

    task print_verdict;
        $display("checks %0d mismatches %0d", checks_done, fails);
        if (fails == 0 && checks_done > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask : print_verdict

    // A hung handshake would stall forever, so the run is capped.
    always @(posedge clk)
    begin
        cycles++;
        if (cycles == 5000)
        begin
            fails++;
            print_verdict;
        end
    end

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        checks_done++;
        if (seen !== exp)
        begin
            fails++;
            $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : chk

    // One bus transfer; an idle edge follows so psel is never rewritten in one time step.
    task automatic apb(input logic w, input logic [IDX_W-1:0] idx, input logic [7:0] wd);
        req <= '{1'b1, 1'b0, w, {idx, 2'b00}, {24'h00_0000, wd}};
        @(posedge clk);
        req.penable <= 1'b1;
        // Only the bench timeout ends a wait for the answer.
        do @(posedge clk); while (rsp.pready !== 1'b1);
        rd = rsp.prdata;
        er = rsp.pslverr;
        req.psel <= 1'b0;
        req.penable <= 1'b0;
        @(posedge clk);
    endtask : apb

    // Writes also update the register model, keeping only the writable bits, except card supply control, which keeps all eight.
    task automatic wr(input logic [IDX_W-1:0] idx, input logic [7:0] d);
        apb(1'b1, idx, d);
        shadow[idx] = d & (idx == IDX_CARD_SIGNAL_CONTROL ? MASK_SIGNAL_CTL :
            idx == IDX_SUPPLY_FAULT_CONTROL ? MASK_FAULT_CTL : idx == IDX_IRQ_MASK ? 8'h03 : 8'hff);
    endtask : wr

    task automatic rdChk(input logic [IDX_W-1:0] idx);
        apb(1'b0, idx, 8'h00);
        chk(rd, {24'h00_0000, shadow[idx]});
    endtask : rdChk

    task automatic ticks(input int n);
        repeat (n)
        begin
            etuTick <= 1'b1;
            @(posedge clk);
            etuTick <= 1'b0;
            repeat (3) @(posedge clk);
        end
    endtask : ticks

    // Main sequence: registers, hold and delay release, select, interrupts, supply fault.
    initial
    begin
        shadow[IDX_CARD_SIGNAL_CONTROL] = RST_SIGNAL_CTL;
        shadow[IDX_RESET_RELEASE_DELAY] = RST_RESET_DELAY;
        shadow[IDX_SUPPLY_FAULT_CONTROL] = RST_SUPPLY_FAULT;
        shadow[IDX_IRQ_MASK] = {6'h00, RST_IRQ};
        repeat (3) @(posedge clk);
        rst_n <= 1'b1;
        chk(32'(resetN), 32'h0000_0000);
        rdChk(IDX_RESET_RELEASE_DELAY);
        rdChk(IDX_SUPPLY_FAULT_CONTROL);
        rdChk(IDX_IRQ_MASK);
        apb(1'b0, 16'h0123, 8'h00);
        chk({er, rd[30:0]}, 32'h8000_0000);
        wr(IDX_CARD_SIGNAL_CONTROL, 8'hff);
        rdChk(IDX_CARD_SIGNAL_CONTROL);
        wr(IDX_RESET_RELEASE_DELAY, 8'h03);
        rdChk(IDX_RESET_RELEASE_DELAY);
        supplyGood <= 1'b1;
        ticks(5);
        chk(32'(resetN), 32'h0000_0000);
        wr(IDX_CARD_SUPPLY_CONTROL, 8'hff);
        apb(1'b0, IDX_CARD_SUPPLY_CONTROL, 8'h00);
        chk(rd & 32'h0000_0008, 32'h0000_0008);
        chk(rd & 32'h0000_00e9, 32'h0000_00c9);
        wr(IDX_CARD_SIGNAL_CONTROL, 8'h00);
        ticks(2);
        chk(32'(resetN), 32'h0000_0000);
        ticks(1);
        chk(32'(resetN), 32'h0000_0001);
        chk(32'(releases), 32'h0000_0001);
        wr(IDX_CARD_SIGNAL_CONTROL, 8'h80);
        repeat (2) @(posedge clk);
        chk(32'(resetN), 32'h0000_0000);
        wr(IDX_RESET_RELEASE_DELAY, 8'h00);
        supplyGood <= 1'b0;
        wr(IDX_CARD_SIGNAL_CONTROL, 8'h00);
        chk(32'(resetN), 32'h0000_0000);
        supplyGood <= 1'b1;
        repeat (3) @(posedge clk);
        chk(32'(resetN), 32'h0000_0001);
        sel <= 1'b1;
        repeat (4) @(posedge clk);
        chk(32'(resetN), 32'h0000_0002);
        chk(32'(irq), 32'h0000_0000);
        wr(IDX_IRQ_MASK, 8'h01);
        repeat (2) @(posedge clk);
        chk(32'(irq), 32'h0000_0001);
        apb(1'b0, IDX_IRQ_STATUS, 8'h00);
        chk(rd & 32'h0000_0001, 32'h0000_0001);
        repeat (2) @(posedge clk);
        chk(32'(irq), 32'h0000_0000);
        // Every threshold code against a random comparator picture.
        for (int c = 0; c < 8; c++)
        begin
            vdd <= 8'($random(seed));
            wr(IDX_SUPPLY_FAULT_CONTROL, 8'h40 | 8'(c));
            repeat (3) @(posedge clk);
            chk(32'(deact), 32'(!vdd[c]));
            apb(1'b0, IDX_CARD_SUPPLY_CONTROL, 8'h00);
            chk(32'(rd[5]), 32'(!vdd[c]));
        end
        rdChk(IDX_SUPPLY_FAULT_CONTROL);
        vdd <= 8'hfe;
        wr(IDX_SUPPLY_FAULT_CONTROL, 8'h05);
        wr(IDX_IRQ_MASK, 8'h02);
        chk({30'h0000_0000, deact, resetN[1]}, 32'h0000_0002);
        chk(32'(irq), 32'h0000_0001);
        wr(IDX_SUPPLY_FAULT_CONTROL, 8'h25);
        repeat (3) @(posedge clk);
        chk(32'(deact), 32'h0000_0000);
        apb(1'b0, IDX_IRQ_STATUS, 8'h00);
        chk(rd & 32'h0000_0002, 32'h0000_0002);
        repeat (2) @(posedge clk);
        chk(32'(irq), 32'h0000_0000);
        chk(32'(badRelease), 32'h0000_0000);
        print_verdict;
    end
endmodule : testbench

// *** hw/crrsf_pkg.sv ***
package crrsf_pkg;

    // Bus geometry: printed offsets are word indices, so the byte address is four times each.
    localparam int APB_AW = 18;
    localparam int APB_DW = 32;
    localparam int IDX_W = 16;

    // Register indices.
    localparam logic [IDX_W-1:0] IDX_CARD_SUPPLY_CONTROL = 16'hfe03;
    localparam logic [IDX_W-1:0] IDX_CARD_SIGNAL_CONTROL = 16'hfe0a;
    localparam logic [IDX_W-1:0] IDX_RESET_RELEASE_DELAY = 16'hfe22;
    localparam logic [IDX_W-1:0] IDX_SUPPLY_FAULT_CONTROL = 16'hffd4;
    localparam logic [IDX_W-1:0] IDX_IRQ_STATUS = 16'hfe30;
    localparam logic [IDX_W-1:0] IDX_IRQ_MASK = 16'hfe31;

    // Reset values.
    localparam logic [7:0] RST_RESET_DELAY = 8'h70;
    localparam logic [7:0] RST_SUPPLY_FAULT = 8'h00;
    localparam logic [7:0] RST_SIGNAL_CTL = 8'h00;
    localparam logic [7:0] RST_SUPPLY_CTL = 8'h00;
    localparam logic [1:0] RST_IRQ = 2'h0;

    // Field positions.
    localparam int BIT_HOLD_IN_RESET = 7;
    localparam int BIT_THRESHOLD_OVERRIDE = 6;
    localparam int BIT_FAULT_DISABLE = 5;
    localparam int BIT_SUPPLY_FAULT_FLAG = 5;
    localparam int BIT_SUPPLY_GOOD = 3;
    localparam int THR_HI = 2;
    localparam int IRQ_RELEASE = 0;
    localparam int IRQ_FAULT = 1;

    // Writable bits of the masked registers; the rest read as zero, except supply control bits 5 and 3, which read status.
    localparam logic [7:0] MASK_SUPPLY_CTL = 8'hc1;
    localparam logic [7:0] MASK_SIGNAL_CTL = 8'hbf;
    localparam logic [7:0] MASK_FAULT_CTL = 8'h67;

    localparam int NUM_IF = 2;
    localparam int NUM_THR = 8;

    typedef enum logic [1:0] {SEQ_HOLD, SEQ_COUNT, SEQ_RUN} crrsf_seq_t;

    typedef struct packed {
        logic psel;
        logic penable;
        logic pwrite;
        logic [APB_AW-1:0] paddr;
        logic [APB_DW-1:0] pwdata;
    } crrsf_apb_req_t;

    typedef struct packed {
        logic pready;
        logic pslverr;
        logic [APB_DW-1:0] prdata;
    } crrsf_apb_rsp_t;

endpackage : crrsf_pkg

// *** hw/crrsf_top.sv ***
// Operation
// - Eight-bit ETU reset delay, defaults 0x70.
// - Zero delay releases reset at supply good.
// - Nonzero delay postpones each release by ETUs.
// - Setting hold bit drives card reset low.
// - Clearing hold releases after programmed delay.
// - Hold set before power keeps reset asserted.
// - Sequencing acts on the selected interface.
// - Enabled fault deactivates the active interface.
// - Override bit picks field, else factory threshold.
// - Fault-disable bit one turns detection off.
// - Codes 000..111 select 2.3..3.0 V steps.
`timescale 1ns/100ps

module crrsf_top
    import crrsf_pkg::*;
#(
    // Factory-fused default threshold code; the value is a plain default.
    parameter logic [THR_HI:0] FACTORY_THR = 3'h0
)
(
    input wire logic clk,
    input wire logic rst_n,
    input wire crrsf_apb_req_t apbReq,
    output crrsf_apb_rsp_t apbRsp,
    input wire logic etuTick,
    input wire logic cardSupplyGood,
    input wire logic [0:0] cardSelect,
    input wire logic [NUM_THR-1:0] vddAboveThr,
    output logic [NUM_IF-1:0] cardResetN,
    output logic cardDeactivate,
    output logic irq
);

    typedef struct packed {
        logic [7:0] resetDelayLength;
        logic [7:0] signalCtl;
        logic [7:0] supplyCtl;
        logic [7:0] faultCtl;
        logic [7:0] count;
        crrsf_seq_t seq;
        logic [0:0] selPrev;
        logic faultPrev;
        logic [1:0] irqStatus;
        logic [1:0] irqMask;
        crrsf_apb_rsp_t rsp;
        logic [NUM_IF-1:0] cardResetN;
        logic deactivate;
        logic irq;
    } crrsf_state_t;

    crrsf_state_t s_reg;
    crrsf_state_t s_next;

    logic [THR_HI:0] thrSel;
    logic faultNow;
    logic cardHoldInReset;
    logic thresholdOverride;
    logic supplyFaultDisable;
    logic [IDX_W-1:0] idx;
    logic setupPhase;
    logic accessDone;
    logic relReq;
    logic abort;
    logic countDone;

    // The comparator bank reports one level per threshold code, so the fault is a mux pick.
    always_comb
    begin
        cardHoldInReset = s_reg.signalCtl[BIT_HOLD_IN_RESET];
        thresholdOverride = s_reg.faultCtl[BIT_THRESHOLD_OVERRIDE];
        supplyFaultDisable = s_reg.faultCtl[BIT_FAULT_DISABLE];
        thrSel = thresholdOverride ? s_reg.faultCtl[THR_HI:0] : FACTORY_THR;
        faultNow = !supplyFaultDisable && !vddAboveThr[thrSel];
    end

    // Bus decode helpers; the slave answers in the first access cycle, no wait states.
    always_comb
    begin
        idx = apbReq.paddr[APB_AW-1:2];
        setupPhase = apbReq.psel && !apbReq.penable;
        accessDone = apbReq.psel && apbReq.penable && s_reg.rsp.pready;
    end

    // Release is requested whenever the supply is good and nothing holds the card.
    always_comb
    begin
        abort = cardHoldInReset || !cardSupplyGood || faultNow
            || (cardSelect != s_reg.selPrev);
        relReq = (s_reg.seq == SEQ_HOLD) && !abort;
        countDone = etuTick && (({1'b0, s_reg.count} + 9'h001) >= {1'b0, s_reg.resetDelayLength});
    end

    // Next-state logic for the whole block.
    always_comb
    begin
        s_next = s_reg;
        s_next.selPrev = cardSelect;
        s_next.faultPrev = faultNow;

        // Sequencer: a hold, supply loss, fault or interface change always returns to reset.
        case (s_reg.seq)
            SEQ_HOLD:
            begin
                if (relReq)
                begin
                    s_next.count = 8'h00;
                    if (s_reg.resetDelayLength == 8'h00)
                    begin
                        s_next.seq = SEQ_RUN;
                    end
                    else
                    begin
                        s_next.seq = SEQ_COUNT;
                    end
                end
            end
            SEQ_COUNT:
            begin
                if (abort)
                begin
                    s_next.seq = SEQ_HOLD;
                end
                else if (countDone)
                begin
                    s_next.seq = SEQ_RUN;
                end
                else if (etuTick)
                begin
                    s_next.count = s_reg.count + 8'h01;
                end
            end
            SEQ_RUN:
            begin
                if (abort)
                begin
                    s_next.seq = SEQ_HOLD;
                end
            end
            default:
            begin
                s_next.seq = SEQ_HOLD;
            end
        endcase

        // Only the selected interface is ever released; the others stay in reset.
        for (int i = 0; i < NUM_IF; i++)
        begin
            s_next.cardResetN[i] = (s_next.seq == SEQ_RUN) && (cardSelect == i[0:0]);
        end
        s_next.deactivate = faultNow;

        // Bus response is prepared in the setup cycle so it leaves a flop in the access cycle.
        s_next.rsp.pready = setupPhase;
        s_next.rsp.pslverr = 1'b0;
        s_next.rsp.prdata = '0;
        if (setupPhase)
        begin
            if (idx == IDX_CARD_SUPPLY_CONTROL)
            begin
                s_next.rsp.prdata[7:0] = s_reg.supplyCtl;
                s_next.rsp.prdata[BIT_SUPPLY_FAULT_FLAG] = faultNow;
                s_next.rsp.prdata[BIT_SUPPLY_GOOD] = cardSupplyGood;
            end
            else if (idx == IDX_CARD_SIGNAL_CONTROL)
            begin
                s_next.rsp.prdata[7:0] = s_reg.signalCtl;
            end
            else if (idx == IDX_RESET_RELEASE_DELAY)
            begin
                s_next.rsp.prdata[7:0] = s_reg.resetDelayLength;
            end
            else if (idx == IDX_SUPPLY_FAULT_CONTROL)
            begin
                s_next.rsp.prdata[7:0] = s_reg.faultCtl;
            end
            else if (idx == IDX_IRQ_STATUS)
            begin
                s_next.rsp.prdata[1:0] = s_reg.irqStatus;
            end
            else if (idx == IDX_IRQ_MASK)
            begin
                s_next.rsp.prdata[1:0] = s_reg.irqMask;
            end
            else
            begin
                s_next.rsp.pslverr = 1'b1;
            end
        end

        // Writes land only at the completing access edge.
        if (accessDone && apbReq.pwrite)
        begin
            if (idx == IDX_CARD_SUPPLY_CONTROL)
            begin
                s_next.supplyCtl = apbReq.pwdata[7:0] & MASK_SUPPLY_CTL;
            end
            else if (idx == IDX_CARD_SIGNAL_CONTROL)
            begin
                s_next.signalCtl = apbReq.pwdata[7:0] & MASK_SIGNAL_CTL;
            end
            else if (idx == IDX_RESET_RELEASE_DELAY)
            begin
                s_next.resetDelayLength = apbReq.pwdata[7:0];
            end
            else if (idx == IDX_SUPPLY_FAULT_CONTROL)
            begin
                // Hardware cannot tell when power-up ended; software must time the override.
                s_next.faultCtl = apbReq.pwdata[7:0] & MASK_FAULT_CTL;
            end
            else if (idx == IDX_IRQ_MASK)
            begin
                s_next.irqMask = apbReq.pwdata[1:0];
            end
        end

        // Sticky events: a read clears, and an event in the same cycle wins over the clear.
        if (accessDone && !apbReq.pwrite && (idx == IDX_IRQ_STATUS))
        begin
            s_next.irqStatus = 2'h0;
        end
        if ((s_next.seq == SEQ_RUN) && (s_reg.seq != SEQ_RUN))
        begin
            s_next.irqStatus[IRQ_RELEASE] = 1'b1;
        end
        if (faultNow && !s_reg.faultPrev)
        begin
            s_next.irqStatus[IRQ_FAULT] = 1'b1;
        end
        s_next.irq = |(s_next.irqStatus & s_next.irqMask);
    end

    // The single state register.
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            s_reg.resetDelayLength <= RST_RESET_DELAY;
            s_reg.signalCtl <= RST_SIGNAL_CTL;
            s_reg.supplyCtl <= RST_SUPPLY_CTL;
            s_reg.faultCtl <= RST_SUPPLY_FAULT;
            s_reg.count <= 8'h00;
            s_reg.seq <= SEQ_HOLD;
            s_reg.selPrev <= 1'h0;
            s_reg.faultPrev <= 1'b0;
            s_reg.irqStatus <= RST_IRQ;
            s_reg.irqMask <= RST_IRQ;
            s_reg.rsp <= '0;
            s_reg.cardResetN <= '0;
            s_reg.deactivate <= 1'b0;
            s_reg.irq <= 1'b0;
        end
        else
        begin
            s_reg <= s_next;
        end
    end

    // Outputs leave the state flops directly.
    assign apbRsp = s_reg.rsp;
    assign cardResetN = s_reg.cardResetN;
    assign cardDeactivate = s_reg.deactivate;
    assign irq = s_reg.irq;

    // Checks on the sequencer, the fault path and the bus.
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!rst_n);

    sequence holdSet;
        cardHoldInReset;
    endsequence

    sequence lastTick;
        (s_reg.seq == SEQ_COUNT) && !abort && countDone;
    endsequence

    sequence apbSetup;
        apbReq.psel && !apbReq.penable;
    endsequence

    a_hold_forces_reset: assert property (holdSet |=> (cardResetN == '0))
        else $error("card reset released while hold bit set");

    a_zero_delay_release: assert property (
        (relReq && (s_reg.resetDelayLength == 8'h00)) |=> (cardResetN != '0))
        else $error("zero delay did not release at once");

    a_count_release: assert property (lastTick |=> (s_reg.seq == SEQ_RUN) ##0 (cardResetN != '0))
        else $error("reset not released when delay expired");

    a_no_early_release: assert property ((s_reg.seq == SEQ_COUNT) |-> (cardResetN == '0))
        else $error("reset released during delay count");

    a_count_steps: assert property (
        ((s_reg.seq == SEQ_COUNT) && !abort && etuTick && !countDone)
        |=> (s_reg.count == $past(s_reg.count) + 8'h01))
        else $error("delay counter did not advance on tick");

    a_count_restart: assert property (
        (relReq && (s_reg.resetDelayLength != 8'h00)) |=> (s_reg.count == 8'h00))
        else $error("delay counter not restarted");

    a_select_only: assert property (
        (cardResetN != '0) |-> (cardResetN[~$past(cardSelect)] == 1'b0))
        else $error("unselected interface released");

    a_fault_deact: assert property (faultNow |=> cardDeactivate && (cardResetN == '0))
        else $error("fault did not deactivate interface");

    a_fault_disabled: assert property (supplyFaultDisable |=> !cardDeactivate)
        else $error("disabled fault detection still deactivates");

    a_default_thr: assert property (!thresholdOverride |-> (thrSel == FACTORY_THR))
        else $error("factory threshold not used without override");

    a_delay_reset: assert property (
        $rose(rst_n) |-> (s_reg.resetDelayLength == RST_RESET_DELAY))
        else $error("reset delay default wrong");

    a_apb_answer: assert property (apbSetup |=> apbRsp.pready)
        else $error("no answer in first access cycle");

    a_irq_level: assert property (irq == |(s_reg.irqStatus & s_reg.irqMask))
        else $error("interrupt output disagrees with status and mask");

    // Event flags: a set in the same cycle as a read-clear must survive the clear.
    a_fault_irq: assert property (
        (faultNow && !s_reg.faultPrev) |=> s_reg.irqStatus[IRQ_FAULT])
        else $error("fault onset not latched in status");

    a_release_irq: assert property (
        ((s_reg.seq != SEQ_RUN) && (s_next.seq == SEQ_RUN)) |=> s_reg.irqStatus[IRQ_RELEASE])
        else $error("reset release not latched in status");

    a_status_clear: assert property (
        (accessDone && !apbReq.pwrite && (idx == IDX_IRQ_STATUS)
            && !(faultNow && !s_reg.faultPrev)) |=> !s_reg.irqStatus[IRQ_FAULT])
        else $error("status read did not clear fault flag");

    // A delay written at the completing edge is the one that the next count compares against.
    a_delay_write: assert property (
        (accessDone && apbReq.pwrite && (idx == IDX_RESET_RELEASE_DELAY))
        |=> (s_reg.resetDelayLength == $past(apbReq.pwdata[7:0])))
        else $error("reset delay write lost");

    a_deact_clear: assert property (!faultNow |=> !cardDeactivate)
        else $error("interface deactivated without a fault");

endmodule : crrsf_top
